// ===== pkg/usbeps_pkg.sv
/*
 * constants and types for the endpoint setup block: register offsets,
 * field positions, reset values and the verdict encoding.
 * assumes a 32-bit axi4-lite register bus with byte addresses.
 */
package usbeps_pkg;
   localparam int GEN_EPS = 5;  // general endpoints first..fifth
   localparam int AREAS   = 6;  // fifo areas 0-5
   localparam int AREA_AW = 12; // fifo area address width
   localparam int ALARMS  = 8;  // alarm enable / iso byte registers

   // register byte offsets
   localparam logic [7:0] OFS_EP0   = 8'h00;
   localparam logic [7:0] OFS_GEN   = 8'h04; // + 4 * endpoint
   localparam logic [7:0] OFS_AREA  = 8'h20; // + 4 * area
   localparam logic [7:0] OFS_JOIN  = 8'h40; // + 4 * area
   localparam logic [7:0] OFS_CLR   = 8'h60;
   localparam logic [7:0] OFS_ALARM = 8'h64; // + 4 * alarm register
   localparam logic [7:0] OFS_STAT  = 8'h84;

   // alarm register indices
   localparam int AL_IN_L      = 0;
   localparam int AL_IN_H      = 1;
   localparam int AL_OUT_L     = 2;
   localparam int AL_OUT_H     = 3;
   localparam int AL_IN_ISO_L  = 4;
   localparam int AL_IN_ISO_H  = 5;
   localparam int AL_OUT_ISO_L = 6;
   localparam int AL_OUT_ISO_H = 7;

   // field positions
   localparam int EP0_DIR_BIT  = 0;
   localparam int EP0_SIZE_LSB = 8;
   localparam int GEN_NUM_LSB  = 0;
   localparam int GEN_DIR_BIT  = 4;
   localparam int GEN_TOG_BIT  = 5;
   localparam int GEN_ISO_BIT  = 6;
   localparam int GEN_SIZE_LSB = 16;
   localparam int AREA_END_LSB = 16;
   localparam int STAT_OUT_LSB = 16;

   // writable masks and reset values
   localparam logic [31:0] EP0_MASK = 32'h0000ff01;
   localparam logic [31:0] GEN_MASK = 32'h07ff007f;
   localparam logic [31:0] AREA_MASK = 32'h0fff0fff;
   localparam logic [31:0] EP0_RST  = 32'h00000800;
   localparam logic [31:0] GEN_RST  = 32'h00080000;
   localparam logic [1:0]  RESP_OKAY   = 2'b00;
   localparam logic [1:0]  RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      USBEPS_IGNORE   = 2'b00,
      USBEPS_DISPATCH = 2'b01,
      USBEPS_NAK      = 2'b10
   } usbeps_kind_t;
endpackage

// ===== logic/usbeps_match.sv
/*
 * endpoint lookup: finds which fifo area each endpoint is joined to and
 * which general endpoint owns an incoming token. purely combinational.
 * assumes join and config words come straight from the register file.
 */
`timescale 1ns/1ns
module usbeps_match
   import usbeps_pkg::*;
(
   input  wire logic [3:0]        tok_ep,
   input  wire logic              tok_in,
   input  wire logic [19:0]       gen_num_flat,
   input  wire logic [4:0]        gen_dir,
   input  wire logic [35:0]       join_flat,
   output logic                   ep0_joined,
   output logic [2:0]             ep0_area,
   output logic                   gen_hit,
   output logic [2:0]             gen_idx,
   output logic [2:0]             gen_area,
   output logic                   gen_unjoined
);
   logic [5:0]  joined;
   logic [17:0] area_of;
   logic [4:0]  cfg_hit;
   logic [4:0]  join_hit;

   // per endpoint column: joined flag and lowest joined area
   for (genvar e = 0; e < 6; e++) begin : g_col
      always_comb begin
         joined[e] = 1'b0;
         area_of[e*3 +: 3] = 3'h0;
         for (int a = AREAS - 1; a >= 0; a--) begin
            if (join_flat[a*6 + e]) begin
               joined[e] = 1'b1;
               area_of[e*3 +: 3] = 3'(a);
            end
         end
      end
   end

   // per general endpoint: number and direction compare
   for (genvar k = 0; k < GEN_EPS; k++) begin : g_gen
      assign cfg_hit[k]  = (gen_num_flat[k*4 +: 4] == tok_ep) &&
                           (gen_dir[k] == tok_in) && (tok_ep != 4'h0);
      assign join_hit[k] = cfg_hit[k] && joined[k+1];
   end

   // joined match wins over an unjoined one with the same number
   always_comb begin
      gen_idx  = 3'h0;
      gen_area = 3'h0;
      for (int k = GEN_EPS - 1; k >= 0; k--) begin
         if (join_hit[k]) begin
            gen_idx  = 3'(k);
            gen_area = area_of[(k+1)*3 +: 3];
         end
      end
   end

   assign ep0_joined   = joined[0];
   assign ep0_area     = area_of[2:0];
   assign gen_hit      = |join_hit;
   assign gen_unjoined = (|cfg_hit) && !gen_hit;
endmodule

// ===== logic/usbeps_top.sv
/*
 * endpoint setup and fifo area linking with an axi4-lite register file.
 * assumes the token decoder runs on sys_clk and pulses tok_valid once per
 * token; the fifo engine consumes the verdict and the area pulses.
 */
// Overview of operation
// - control endpoint zero plus five general endpoints
// - alarm on up to fifteen in/out numbers
// - enabled alarm, no general match: nak, notify
// - endpoint zero direction from one shared register
// - endpoint zero moves no data until joined
// - general endpoints own number and direction
// - unjoined general endpoint executes no transaction
// - alarm endpoints need no fifo area
// - alarm enables per number, low and high groups
`timescale 1ns/1ns
module usbeps_top
   import usbeps_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              srst,
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              tok_valid,
   input  wire logic [3:0]        tok_ep,
   input  wire logic              tok_in,
   output logic                   res_valid,
   output usbeps_kind_t           res_kind,
   output logic [2:0]             res_ep,
   output logic [2:0]             res_area,
   output logic                   res_dir,
   output logic                   res_iso,
   output logic                   res_toggle_mode,
   output logic [10:0]            res_max_size,
   output logic                   res_alarm,
   output logic [5:0]             fifo_area_clear,
   output logic [AREAS*24-1:0]    area_bounds_flat
);
   logic [31:0] ep0_reg, ep0_next;
   logic [31:0] gen_reg   [GEN_EPS], gen_next   [GEN_EPS];
   logic [31:0] area_reg  [AREAS],   area_next  [AREAS];
   logic [5:0]  join_reg  [AREAS],   join_next  [AREAS];
   logic [7:0]  alarm_reg [ALARMS],  alarm_next [ALARMS];
   logic [31:0] stat_reg, stat_next;
   logic [5:0]  clr_reg, clr_next;
   logic [7:0]  awaddr_reg, awaddr_next;
   logic [31:0] wdata_reg, wdata_next;
   logic [3:0]  wstrb_reg, wstrb_next;
   logic        aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
   logic        bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
   logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next;
   logic        rv_reg, rv_next, ra_reg, ra_next;
   usbeps_kind_t rk_reg, rk_next;
   logic [2:0]  re_reg, re_next, rar_reg, rar_next;
   logic        rd_reg, rd_next, ri_reg, ri_next, rt_reg, rt_next;
   logic [10:0] rs_reg, rs_next;
   logic [19:0] gen_num_flat;
   logic [4:0]  gen_dir;
   logic [35:0] join_flat;
   logic [15:0] en_in, en_out, iso_in, iso_out;
   logic        ep0_joined, gen_hit, gen_unjoined, alarm_hit;
   logic [2:0]  ep0_area, gen_idx, gen_area;
   logic [31:0] bmask, wval, gcfg;
   logic        do_write;

   // flatten configuration for the lookup and the fifo engine
   for (genvar i = 0; i < AREAS; i++) begin : g_area
      assign join_flat[i*6 +: 6] = join_reg[i];
      assign area_bounds_flat[i*24 +: 24] =
         {area_reg[i][AREA_END_LSB +: AREA_AW], area_reg[i][AREA_AW-1:0]};
   end
   for (genvar k = 0; k < GEN_EPS; k++) begin : g_cfg
      assign gen_num_flat[k*4 +: 4] = gen_reg[k][GEN_NUM_LSB +: 4];
      assign gen_dir[k] = gen_reg[k][GEN_DIR_BIT];
   end

   // alarm vectors indexed by endpoint number, number zero never alarms
   assign en_in   = {alarm_reg[AL_IN_H], alarm_reg[AL_IN_L][7:1], 1'b0};
   assign en_out  = {alarm_reg[AL_OUT_H], alarm_reg[AL_OUT_L][7:1], 1'b0};
   assign iso_in  = {alarm_reg[AL_IN_ISO_H], alarm_reg[AL_IN_ISO_L][7:1],
                     1'b0};
   assign iso_out = {alarm_reg[AL_OUT_ISO_H], alarm_reg[AL_OUT_ISO_L][7:1],
                     1'b0};
   assign alarm_hit = tok_in ? en_in[tok_ep] : en_out[tok_ep];

   usbeps_match u_match (
      .tok_ep       (tok_ep),
      .tok_in       (tok_in),
      .gen_num_flat (gen_num_flat),
      .gen_dir      (gen_dir),
      .join_flat    (join_flat),
      .ep0_joined   (ep0_joined),
      .ep0_area     (ep0_area),
      .gen_hit      (gen_hit),
      .gen_idx      (gen_idx),
      .gen_area     (gen_area),
      .gen_unjoined (gen_unjoined)
   );

   // byte lanes merged before the writable mask
   assign bmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                   {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
   assign wval  = wdata_reg & bmask;
   assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
   assign gcfg = gen_reg[gen_idx];

   // register file, bus slave and token verdict
   always_comb begin
      ep0_next = ep0_reg;
      gen_next = gen_reg;
      area_next = area_reg;
      join_next = join_reg;
      alarm_next = alarm_reg;
      stat_next = stat_reg;
      clr_next = 6'h00;
      awaddr_next = awaddr_reg;
      wdata_next = wdata_reg;
      wstrb_next = wstrb_reg;
      aw_hold_next = aw_hold_reg;
      w_hold_next = w_hold_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg;
      rresp_next = rresp_reg;
      rdata_next = rdata_reg;
      // address and data taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
         awaddr_next = s_axi_awaddr;
         aw_hold_next = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wdata_next = s_axi_wdata;
         wstrb_next = s_axi_wstrb;
         w_hold_next = 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
      if (do_write) begin
         aw_hold_next = 1'b0;
         w_hold_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = RESP_OKAY;
         if (awaddr_reg[7:2] == OFS_EP0[7:2]) begin
            ep0_next = ((ep0_reg & ~bmask) | wval) & EP0_MASK;
         end else if (awaddr_reg >= OFS_GEN &&
                      awaddr_reg < OFS_GEN + 8'h14) begin
            gen_next[awaddr_reg[4:2] - 3'h1] = ((gen_reg[awaddr_reg[4:2] -
               3'h1] & ~bmask) | wval) & GEN_MASK;
         end else if (awaddr_reg >= OFS_AREA &&
                      awaddr_reg < OFS_AREA + 8'h18) begin
            area_next[3'(awaddr_reg[7:2] - OFS_AREA[7:2])] =
               ((area_reg[3'(awaddr_reg[7:2] - OFS_AREA[7:2])] & ~bmask) |
               wval) & AREA_MASK;
         end else if (awaddr_reg >= OFS_JOIN &&
                      awaddr_reg < OFS_JOIN + 8'h18) begin
            if (wstrb_reg[0]) begin
               join_next[3'(awaddr_reg[7:2] - OFS_JOIN[7:2])] =
                  wdata_reg[5:0];
            end
         end else if (awaddr_reg[7:2] == OFS_CLR[7:2]) begin
            clr_next = wval[5:0];
         end else if (awaddr_reg >= OFS_ALARM && awaddr_reg < OFS_STAT) begin
            if (wstrb_reg[0]) begin
               alarm_next[3'(awaddr_reg[7:2] - OFS_ALARM[7:2])] =
                  wdata_reg[7:0];
            end
         end else if (awaddr_reg[7:2] == OFS_STAT[7:2]) begin
            stat_next = stat_reg & ~wval; // write one to clear
         end else begin
            bresp_next = RESP_SLVERR;
         end
      end
      // read answer one cycle after the address is taken
      if (s_axi_rvalid && s_axi_rready) begin
         rvalid_next = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_next = 1'b1;
         rresp_next = RESP_OKAY;
         rdata_next = 32'h00000000;
         if (s_axi_araddr[7:2] == OFS_EP0[7:2]) begin
            rdata_next = ep0_reg;
         end else if (s_axi_araddr >= OFS_GEN &&
                      s_axi_araddr < OFS_GEN + 8'h14) begin
            rdata_next = gen_reg[s_axi_araddr[4:2] - 3'h1];
         end else if (s_axi_araddr >= OFS_AREA &&
                      s_axi_araddr < OFS_AREA + 8'h18) begin
            rdata_next = area_reg[3'(s_axi_araddr[7:2] - OFS_AREA[7:2])];
         end else if (s_axi_araddr >= OFS_JOIN &&
                      s_axi_araddr < OFS_JOIN + 8'h18) begin
            rdata_next[5:0] = join_reg[3'(s_axi_araddr[7:2] -
                                         OFS_JOIN[7:2])];
         end else if (s_axi_araddr[7:2] == OFS_CLR[7:2]) begin
            rdata_next = 32'h00000000; // clear strobes read as zero
         end else if (s_axi_araddr >= OFS_ALARM &&
                      s_axi_araddr < OFS_STAT) begin
            rdata_next[7:0] = alarm_reg[3'(s_axi_araddr[7:2] -
                                          OFS_ALARM[7:2])];
            // low groups sit at the odd word offsets
            if (s_axi_araddr[2]) begin
               rdata_next[0] = 1'b0; // low groups start at number one
            end
         end else if (s_axi_araddr[7:2] == OFS_STAT[7:2]) begin
            rdata_next = stat_reg;
         end else begin
            rresp_next = RESP_SLVERR;
         end
      end
      // token verdict; the alarm set below overrides a same-cycle clear
      rv_next = tok_valid;
      rk_next = USBEPS_IGNORE;
      re_next = 3'h0;
      rar_next = 3'h0;
      rd_next = tok_valid && tok_in;
      ri_next = 1'b0;
      rt_next = 1'b0;
      rs_next = 11'h000;
      ra_next = 1'b0;
      if (tok_valid) begin
         if (tok_ep == 4'h0) begin
            rd_next = ep0_reg[EP0_DIR_BIT];
            rs_next = {3'h0, ep0_reg[EP0_SIZE_LSB +: 8]};
            rar_next = ep0_area;
            rk_next = ep0_joined ? USBEPS_DISPATCH : USBEPS_NAK;
         end else if (gen_hit) begin
            rk_next = USBEPS_DISPATCH;
            re_next = gen_idx + 3'h1;
            rar_next = gen_area;
            ri_next = gcfg[GEN_ISO_BIT];
            rt_next = gcfg[GEN_TOG_BIT];
            rs_next = gcfg[GEN_SIZE_LSB +: 11];
         end else if (gen_unjoined) begin
            rk_next = USBEPS_NAK;
         end else if (alarm_hit) begin
            rk_next = USBEPS_NAK;
            ra_next = 1'b1;
            ri_next = tok_in ? iso_in[tok_ep] : iso_out[tok_ep];
            stat_next[(tok_in ? 0 : STAT_OUT_LSB) + int'(tok_ep)] = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ep0_reg <= EP0_RST;
         for (int k = 0; k < GEN_EPS; k++) gen_reg[k] <= GEN_RST;
         for (int a = 0; a < AREAS; a++) begin
            area_reg[a] <= 32'h00000000;
            join_reg[a] <= 6'h00;
         end
         for (int j = 0; j < ALARMS; j++) alarm_reg[j] <= 8'h00;
         stat_reg <= 32'h00000000;
         clr_reg <= 6'h00;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         rvalid_reg <= 1'b0;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= 32'h00000000;
         rv_reg <= 1'b0;
         rk_reg <= USBEPS_IGNORE;
         re_reg <= 3'h0;
         rar_reg <= 3'h0;
         rd_reg <= 1'b0;
         ri_reg <= 1'b0;
         rt_reg <= 1'b0;
         rs_reg <= 11'h000;
         ra_reg <= 1'b0;
      end else begin
         ep0_reg <= ep0_next;
         gen_reg <= gen_next;
         area_reg <= area_next;
         join_reg <= join_next;
         alarm_reg <= alarm_next;
         stat_reg <= stat_next;
         clr_reg <= clr_next;
         awaddr_reg <= awaddr_next;
         wdata_reg <= wdata_next;
         wstrb_reg <= wstrb_next;
         aw_hold_reg <= aw_hold_next;
         w_hold_reg <= w_hold_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rresp_reg <= rresp_next;
         rdata_reg <= rdata_next;
         rv_reg <= rv_next;
         rk_reg <= rk_next;
         re_reg <= re_next;
         rar_reg <= rar_next;
         rd_reg <= rd_next;
         ri_reg <= ri_next;
         rt_reg <= rt_next;
         rs_reg <= rs_next;
         ra_reg <= ra_next;
      end
   end

   // one write and one read in flight; ready drops while holding
   assign s_axi_awready = !aw_hold_reg;
   assign s_axi_wready = !w_hold_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;
   assign res_valid = rv_reg;
   assign res_kind = rk_reg;
   assign res_ep = re_reg;
   assign res_area = rar_reg;
   assign res_dir = rd_reg;
   assign res_iso = ri_reg;
   assign res_toggle_mode = rt_reg;
   assign res_max_size = rs_reg;
   assign res_alarm = ra_reg;
   assign fifo_area_clear = clr_reg;

   sequence s_alarm_tok;
      tok_valid && tok_ep != 4'h0 && !gen_hit && !gen_unjoined && alarm_hit;
   endsequence
   sequence s_alarm_res;
      res_valid && res_kind == USBEPS_NAK && res_alarm;
   endsequence
   property p_alarm_nak;
      @(posedge sys_clk) disable iff (srst) s_alarm_tok |=> s_alarm_res;
   endproperty
   a_alarm_nak: assert property (p_alarm_nak)
      else $error("alarm token not answered with nak");
   property p_alarm_stat;
      @(posedge sys_clk) disable iff (srst)
         s_alarm_tok and tok_in |=> stat_reg[$past(tok_ep)];
   endproperty
   a_alarm_stat: assert property (p_alarm_stat)
      else $error("alarm status bit not set");
   property p_ep0_unjoined;
      @(posedge sys_clk) disable iff (srst)
         tok_valid && tok_ep == 4'h0 && !ep0_joined
         |=> res_kind == USBEPS_NAK;
   endproperty
   a_ep0_unjoined: assert property (p_ep0_unjoined)
      else $error("endpoint zero moved data while unjoined");
   property p_ep0_dir;
      @(posedge sys_clk) disable iff (srst)
         tok_valid && tok_ep == 4'h0 |=> res_dir == $past(ep0_reg[0]);
   endproperty
   a_ep0_dir: assert property (p_ep0_dir)
      else $error("endpoint zero direction not from register");
   property p_gen_joined;
      @(posedge sys_clk) disable iff (srst)
         tok_valid && gen_hit
         |-> join_flat[gen_area*6 + gen_idx + 1];
   endproperty
   a_gen_joined: assert property (p_gen_joined)
      else $error("general endpoint dispatched without join");
   property p_gen_route;
      @(posedge sys_clk) disable iff (srst)
         tok_valid && tok_ep != 4'h0 && gen_hit
         |=> res_kind == USBEPS_DISPATCH && res_ep == $past(gen_idx) + 3'h1;
   endproperty
   a_gen_route: assert property (p_gen_route)
      else $error("matching general endpoint not dispatched");
   property p_ep_range;
      @(posedge sys_clk) disable iff (srst) res_valid |-> res_ep <= 3'h5;
   endproperty
   a_ep_range: assert property (p_ep_range)
      else $error("endpoint index out of range");
   property p_alarm_low_zero;
      @(posedge sys_clk) disable iff (srst)
         tok_valid && tok_ep == 4'h0 |=> !res_alarm;
   endproperty
   a_alarm_low_zero: assert property (p_alarm_low_zero)
      else $error("endpoint zero raised an alarm");
   property p_bvalid_hold;
      @(posedge sys_clk) disable iff (srst)
         s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(bresp_reg);
   endproperty
   a_bvalid_hold: assert property (p_bvalid_hold)
      else $error("write response dropped early");
endmodule

// ===== tb/usbeps_host_model.sv
/*
 usb host stand-in: issues one token at a time toward the block.
 assumes the bench calls send from its main sequence on sys_clk.
*/
`timescale 1ns/1ns
module usbeps_host_model (
   input  wire logic sys_clk,
   output logic      tok_valid,
   output logic [3:0] tok_ep,
   output logic      tok_in
);
   initial begin
      tok_valid = 1'b0;
      tok_ep    = 4'h0;
      tok_in    = 1'b0;
   end
   // one-cycle token; idle lines invert so stale values never match
   task automatic send(input logic [3:0] ep, input logic dir);
      @(posedge sys_clk);
      tok_valid <= 1'b1;
      tok_ep    <= ep;
      tok_in    <= dir;
      @(posedge sys_clk);
      tok_valid <= 1'b0;
      tok_ep    <= ~ep;
      tok_in    <= ~dir;
   endtask
endmodule

// ===== tb/tb_usb_device_endpoint_setup.sv
/*
 self-checking bench: axi4-lite register tasks plus token scenarios.
 assumes usbeps_top and the host model; 25 mhz sys_clk.
*/
`timescale 1ns/1ns
module tb_usb_device_endpoint_setup;
   import usbeps_pkg::*;
   logic sys_clk = 1'b0, srst = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hf, tok_ep;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
   logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic tok_valid, tok_in, res_valid, res_dir, res_iso;
   logic res_toggle_mode, res_alarm;
   usbeps_kind_t res_kind;
   logic [2:0] res_ep, res_area;
   logic [10:0] res_max_size;
   logic [5:0] fifo_area_clear, clr_seen = 6'h0;
   logic [143:0] area_bounds_flat;
   int err_total = 0, checks_done = 0;
   always #20 sys_clk = ~sys_clk;
   usbeps_top usbeps_top_inst (.sys_clk, .srst, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .tok_valid, .tok_ep, .tok_in, .res_valid, .res_kind, .res_ep,
      .res_area, .res_dir, .res_iso, .res_toggle_mode, .res_max_size,
      .res_alarm, .fifo_area_clear, .area_bounds_flat);
   usbeps_host_model usbeps_host_model_inst (.sys_clk, .tok_valid,
      .tok_ep, .tok_in);
   // clear pulses last only a cycle, so latch whatever shows up
   always @(posedge sys_clk) if (fifo_area_clear != 6'h0)
      clr_seen <= fifo_area_clear;
   task automatic wrap_up;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // readies sampled at negedge, released right after the taking edge;
   // bready rises only once bvalid shows, so the response must hold
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb, tv;
      @(posedge sys_clk);
      s_axi_awaddr <= a; s_axi_wdata <= d;
      s_axi_awvalid <= 1; s_axi_wvalid <= 1;
      for (int i = 0; i < 20; i++) begin
         @(negedge sys_clk);
         ta = s_axi_awready; tw = s_axi_wready; tv = s_axi_bvalid;
         tb = s_axi_bvalid && s_axi_bready;
         rs = s_axi_bresp;
         @(posedge sys_clk);
         if (ta) s_axi_awvalid <= 0;
         if (tw) s_axi_wvalid <= 0;
         if (tb) begin s_axi_bready <= 0; return; end
         if (tv) s_axi_bready <= 1;
      end
      err_total++; wrap_up();
   endtask
   task automatic rdr(input logic [7:0] a);
      logic ta, tr;
      @(posedge sys_clk);
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      for (int i = 0; i < 20; i++) begin
         @(negedge sys_clk);
         ta = s_axi_arready; tr = s_axi_rvalid;
         rd = s_axi_rdata; rs = s_axi_rresp;
         @(posedge sys_clk);
         if (ta) s_axi_arvalid <= 0;
         if (tr) begin s_axi_rready <= 0; return; end
      end
      err_total++; wrap_up();
   endtask
   // verdict word {valid,kind,ep,alarm}; dispatch adds {area,dir,size}
   task automatic tk(input logic [3:0] ep, input logic dir,
      input logic [5:0] ev, input logic [14:0] dv);
      usbeps_host_model_inst.send(ep, dir);
      #1;
      chk({25'h0, res_valid, res_kind, res_ep, res_alarm},
          {25'h0, 1'b1, ev});
      if (ev[5:4] == 2'b01)
         chk({17'h0, res_area, res_dir, res_max_size}, {17'h0, dv});
   endtask
   task automatic sc_reset;
      rdr(OFS_EP0); chk(rd, EP0_RST);
      rdr(OFS_GEN); chk(rd, GEN_RST);
      rdr(8'hfc); chk({30'h0, rs}, {30'h0, RESP_SLVERR});
      chk(rd, 32'h0);
      wr(8'h18, 32'h1); chk({30'h0, rs}, {30'h0, RESP_SLVERR});
   endtask
   task automatic sc_ep0;
      tk(4'h0, 1'b0, 6'b10_000_0, 15'h0);
      wr(OFS_EP0, 32'h0801);
      wr(OFS_AREA, 32'h00ff0000);
      chk({8'h0, area_bounds_flat[23:0]}, 32'h000ff000);
      wr(OFS_CLR, 32'h1); chk({26'h0, clr_seen}, 32'h1);
      wr(OFS_JOIN, 32'h1);
      tk(4'h0, 1'b0, 6'b01_000_0, {3'd0, 1'b1, 11'h8});
   endtask
   // interrupt in endpoint first, then an isochronous out endpoint
   task automatic sc_general;
      wr(OFS_GEN + 8'h04, 32'h00400033);
      tk(4'h3, 1'b1, 6'b10_000_0, 15'h0);
      wr(OFS_AREA + 8'h04, 32'h01ff0100);
      wr(OFS_CLR, 32'h2); chk({26'h0, clr_seen}, 32'h2);
      wr(OFS_JOIN + 8'h04, 32'h4);
      tk(4'h3, 1'b1, 6'b01_010_0, {3'd1, 1'b1, 11'h40});
      chk({30'h0, res_iso, res_toggle_mode}, 32'h1);
      tk(4'h3, 1'b0, 6'b00_000_0, 15'h0);
      wr(OFS_GEN, 32'h03ff0046);
      wr(OFS_AREA + 8'h08, 32'h05ff0200);
      wr(OFS_CLR, 32'h4); chk({26'h0, clr_seen}, 32'h4);
      wr(OFS_JOIN + 8'h08, 32'h2);
      tk(4'h6, 1'b0, 6'b01_001_0, {3'd2, 1'b0, 11'h3ff});
      chk({30'h0, res_iso, res_toggle_mode}, 32'h2);
   endtask
   task automatic sc_alarm;
      wr(OFS_ALARM, 32'h21);
      wr(OFS_ALARM + 8'h10, 32'h20);
      tk(4'h5, 1'b1, 6'b10_000_1, 15'h0);
      chk({31'h0, res_iso}, 32'h1);
      wr(OFS_ALARM + 8'h0c, 32'h03);
      tk(4'h9, 1'b0, 6'b10_000_1, 15'h0);
      tk(4'h9, 1'b1, 6'b00_000_0, 15'h0);
      rdr(OFS_STAT); chk(rd, 32'h02000020);
      rdr(OFS_ALARM); chk(rd, 32'h20);
      rdr(OFS_ALARM + 8'h0c); chk(rd, 32'h03);
   endtask
   initial begin
      repeat (16) @(posedge sys_clk);
      srst <= 1'b0;
      sc_reset();
      sc_ep0();
      sc_general();
      sc_alarm();
      wrap_up();
   end
endmodule
